// ===== cdsfi_pkg.sv
// package of constants and types for the core data space, flags and interrupt block
// Operation
// - data space holds 128 bytes: 40 special locations and 88 RAM bytes
// - pointers at 01H/03H, working 05H, pc low 06H, status 0AH, control 0BH
// - unassigned locations below 28H read 00H; RAM spans 28H to 7FH
// - single-bit set and clear work on every location except protected bits
// - addresses 00H and 02H redirect to the location held in their 7-bit pointer
// - indirect access to an indirect window reads 00H and writes nothing
// - status follows each ALU result; writes leave watchdog and sleep flags alone
// - bit 0 is carry or no-borrow, also updated by rotate through carry
// - bit 1 is low-nibble carry or no-borrow from the high nibble
// - bit 2 set when the result is zero
// - bit 3 set when carry into msb differs from carry out
// - bit 4 clears at power-up and watchdog clear, sets on sleep
// - bit 5 clears on power-up, watchdog clear, sleep; sets on timeout; bits 6,7 zero
// - status is never saved automatically; only the program counter is pushed
// - servicing clears global enable; later requests only set pending flags
// - no acknowledge while the return stack is full; acknowledge after it pops
// - each of the three sources wakes the core from sleep when its own source enable is set
// - acknowledge pushes the program counter then branches to the source vector
// - falling edge on external pin sets bit 4; service calls 04H, clears flag and global enable
// - timer overflow sets bit 5; service calls 08H, clears flag and global enable
// - conversion end sets bit 6; service calls 0CH, clears flag and global enable
// - setting global and source enable inside a routine allows nesting
// - control bit 0 global, bits 1-3 source enables; bit 7 test-only, write 0
// - priority is external, then timer, then conversion
// - return-from-irq sets global enable; plain return leaves it unchanged
// - pending flag stays set until serviced or cleared by software
package cdsfi_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] ADR_WIN0 = 7'h00;
    localparam logic [6:0] ADR_PTR0 = 7'h01;
    localparam logic [6:0] ADR_WIN1 = 7'h02;
    localparam logic [6:0] ADR_PTR1 = 7'h03;
    localparam logic [6:0] ADR_WORK = 7'h05;
    localparam logic [6:0] ADR_PCL = 7'h06;
    localparam logic [6:0] ADR_TBLPTR = 7'h07;
    localparam logic [6:0] ADR_TBLHI = 7'h08;
    localparam logic [6:0] ADR_STATUS = 7'h0A;
    localparam logic [6:0] ADR_IRQCTL = 7'h0B;
    localparam logic [6:0] RAM_FIRST = 7'h28;
    localparam logic [6:0] RAM_LAST = 7'h7F;
    localparam int RAM_DEPTH = 88;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // status bit positions
    localparam int ST_C = 0;
    localparam int ST_AC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_PDF = 4;
    localparam int ST_TO = 5;
    localparam logic [7:0] ST_SW_MASK = 8'h0F;
    // irq control bit positions
    localparam int IC_GIE = 0;
    localparam int IC_EXT_EN = 1;
    localparam int IC_TMR_EN = 2;
    localparam int IC_CNV_EN = 3;
    localparam int IC_EXT_PEND = 4;
    localparam int IC_TMR_PEND = 5;
    localparam int IC_CNV_PEND = 6;
    localparam logic [7:0] IC_SW_MASK = 8'h7F;
    localparam logic [10:0] VEC_EXT = 11'h004;
    localparam logic [10:0] VEC_TMR = 11'h008;
    localparam logic [10:0] VEC_CNV = 11'h00C;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [2:0] {
        CDSFI_OP_NONE = 3'h0,
        CDSFI_OP_WRITE = 3'h1,
        CDSFI_OP_BITSET = 3'h2,
        CDSFI_OP_BITCLR = 3'h3
    } cdsfi_op_e;

    // one data-space access from the pipeline
    typedef struct packed {
        cdsfi_op_e op;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [2:0] bitSel;
    } cdsfi_access_s;

    // ALU result flags to fold into status
    typedef struct packed {
        logic valid;
        logic carryValid;
        logic carry;
        logic arith;
        logic halfCarry;
        logic carryIntoMsb;
        logic [7:0] result;
    } cdsfi_alu_s;

    typedef enum logic [3:0] {
        CDSFI_SRC_NONE = 4'h1,
        CDSFI_SRC_EXT = 4'h2,
        CDSFI_SRC_TMR = 4'h4,
        CDSFI_SRC_CNV = 4'h8
    } cdsfi_src_e;
endpackage

// ===== cdsfi_core.sv
// data space decoder, status flags and interrupt sequencer of the core
`timescale 1ns/1ps
module cdsfi_core #(
    parameter int PC_W = 11
) (
    input wire logic clk,
    input wire logic rstn,
    input wire cdsfi_pkg::cdsfi_access_s acc,
    input wire logic [6:0] rdAddr,
    output logic [7:0] rdData,
    input wire cdsfi_pkg::cdsfi_alu_s alu,
    input wire logic [7:0] workIn,
    input wire logic workLoad,
    input wire logic [7:0] pcLowIn,
    input wire logic [7:0] tableHighIn,
    input wire logic tableHighLoad,
    input wire logic sleepExec,
    input wire logic wdtClearExec,
    input wire logic wdtTimeout,
    input wire logic retFromIrq,
    input wire logic stackFull,
    input wire logic irqTake,
    input wire logic extIrqPinN,
    input wire logic timerOverflow,
    input wire logic conversionDone,
    output logic [7:0] workingRegister,
    output logic [7:0] programCounterLow,
    output logic [7:0] tablePointer,
    output logic pclWritten,
    output logic irqRequest,
    output logic [PC_W-1:0] irqVector,
    output logic wake
);
    logic [6:0] dataPointer0;
    logic [6:0] dataPointer1;
    logic [7:0] tableHighLatch;
    logic [7:0] statusFlags;
    logic [7:0] irqControl;
    logic [7:0] ram [cdsfi_pkg::RAM_DEPTH];
    logic extPinLast;
    logic [6:0] wrTarget;
    logic wrWindowHit;
    logic [7:0] curByte;
    logic [7:0] newByte;
    logic wrEn;
    logic [6:0] rdTarget;
    logic rdWindowHit;

    typedef logic [3:0] cdsfi_src_pick_t;

    cdsfi_src_pick_t pick;

    // resolve windows to their pointers; shared by read and write paths
    function automatic logic [7:0] resolve(input logic [6:0] a, input logic [6:0] p0,
                                           input logic [6:0] p1);
        logic [7:0] r;
        r = {1'b0, a};
        if (a == cdsfi_pkg::ADR_WIN0) begin
            r = {1'b0, p0};
        end else if (a == cdsfi_pkg::ADR_WIN1) begin
            r = {1'b0, p1};
        end
        if (((a == cdsfi_pkg::ADR_WIN0) || (a == cdsfi_pkg::ADR_WIN1)) &&
            ((r[6:0] == cdsfi_pkg::ADR_WIN0) || (r[6:0] == cdsfi_pkg::ADR_WIN1))) begin
            r[7] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [7:0] peek(input logic [6:0] a);
        logic [7:0] v;
        v = cdsfi_pkg::READ_ZERO;
        case (a)
            cdsfi_pkg::ADR_PTR0: v = {1'b0, dataPointer0};
            cdsfi_pkg::ADR_PTR1: v = {1'b0, dataPointer1};
            cdsfi_pkg::ADR_WORK: v = workingRegister;
            cdsfi_pkg::ADR_PCL: v = pcLowIn;
            cdsfi_pkg::ADR_TBLPTR: v = tablePointer;
            cdsfi_pkg::ADR_TBLHI: v = tableHighLatch;
            cdsfi_pkg::ADR_STATUS: v = statusFlags;
            cdsfi_pkg::ADR_IRQCTL: v = irqControl;
            default: begin
                if (a >= cdsfi_pkg::RAM_FIRST) begin
                    v = ram[a - cdsfi_pkg::RAM_FIRST];
                end
            end
        endcase
        return v;
    endfunction

    always_comb begin
        logic [7:0] w;
        logic [7:0] r;
        w = resolve(acc.addr, dataPointer0, dataPointer1);
        r = resolve(rdAddr, dataPointer0, dataPointer1);
        wrTarget = w[6:0];
        wrWindowHit = w[7];
        rdTarget = r[6:0];
        rdWindowHit = r[7];
        curByte = peek(wrTarget);
        newByte = acc.wdata;
        case (acc.op)
            cdsfi_pkg::CDSFI_OP_BITSET: newByte = curByte | (8'h01 << acc.bitSel);
            cdsfi_pkg::CDSFI_OP_BITCLR: newByte = curByte & ~(8'h01 << acc.bitSel);
            default: newByte = acc.wdata;
        endcase
        wrEn = (acc.op != cdsfi_pkg::CDSFI_OP_NONE) && !wrWindowHit;
    end

    // a process, not an assign: peek reads registers that are not its arguments
    always_comb begin
        rdData = rdWindowHit ? cdsfi_pkg::READ_ZERO : peek(rdTarget);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dataPointer0 <= 7'h00;
            dataPointer1 <= 7'h00;
            tablePointer <= cdsfi_pkg::RESET_BYTE;
            programCounterLow <= cdsfi_pkg::RESET_BYTE;
            pclWritten <= 1'b0;
        end else begin
            pclWritten <= wrEn && (wrTarget == cdsfi_pkg::ADR_PCL);
            if (wrEn && wrTarget == cdsfi_pkg::ADR_PCL) begin
                programCounterLow <= newByte;
            end
            if (wrEn && wrTarget == cdsfi_pkg::ADR_PTR0) begin
                dataPointer0 <= newByte[6:0];
            end
            if (wrEn && wrTarget == cdsfi_pkg::ADR_PTR1) begin
                dataPointer1 <= newByte[6:0];
            end
            if (wrEn && wrTarget == cdsfi_pkg::ADR_TBLPTR) begin
                tablePointer <= newByte;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            workingRegister <= cdsfi_pkg::RESET_BYTE;
            tableHighLatch <= cdsfi_pkg::RESET_BYTE;
        end else begin
            if (workLoad) begin
                workingRegister <= workIn;
            end else if (wrEn && wrTarget == cdsfi_pkg::ADR_WORK) begin
                workingRegister <= newByte;
            end
            if (tableHighLoad) begin
                tableHighLatch <= tableHighIn;
            end
        end
    end

    // ram has no reset: contents are undefined after power-up
    always_ff @(posedge clk) begin
        if (wrEn && wrTarget >= cdsfi_pkg::RAM_FIRST) begin
            ram[wrTarget - cdsfi_pkg::RAM_FIRST] <= newByte;
        end
    end

    // status: software write only reaches the four ALU flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            statusFlags <= cdsfi_pkg::RESET_BYTE;
        end else begin
            if (wrEn && wrTarget == cdsfi_pkg::ADR_STATUS) begin
                statusFlags[3:0] <= newByte[3:0];
            end
            if (alu.valid) begin
                if (alu.carryValid) begin
                    statusFlags[cdsfi_pkg::ST_C] <= alu.carry;
                end
                if (alu.arith) begin
                    statusFlags[cdsfi_pkg::ST_AC] <= alu.halfCarry;
                    statusFlags[cdsfi_pkg::ST_OV] <= alu.carryIntoMsb ^ alu.carry;
                end
                statusFlags[cdsfi_pkg::ST_Z] <= (alu.result == 8'h00);
            end
            if (wdtClearExec) begin
                statusFlags[cdsfi_pkg::ST_PDF] <= 1'b0;
                statusFlags[cdsfi_pkg::ST_TO] <= 1'b0;
            end else if (sleepExec) begin
                statusFlags[cdsfi_pkg::ST_PDF] <= 1'b1;
                statusFlags[cdsfi_pkg::ST_TO] <= 1'b0;
            end
            if (wdtTimeout) begin
                statusFlags[cdsfi_pkg::ST_TO] <= 1'b1;
            end
            statusFlags[7:6] <= 2'b00;
        end
    end

    // priority pick among enabled pending sources
    always_comb begin
        pick = cdsfi_pkg::CDSFI_SRC_NONE;
        if (irqControl[cdsfi_pkg::IC_EXT_PEND] && irqControl[cdsfi_pkg::IC_EXT_EN]) begin
            pick = cdsfi_pkg::CDSFI_SRC_EXT;
        end else if (irqControl[cdsfi_pkg::IC_TMR_PEND] && irqControl[cdsfi_pkg::IC_TMR_EN]) begin
            pick = cdsfi_pkg::CDSFI_SRC_TMR;
        end else if (irqControl[cdsfi_pkg::IC_CNV_PEND] && irqControl[cdsfi_pkg::IC_CNV_EN]) begin
            pick = cdsfi_pkg::CDSFI_SRC_CNV;
        end
    end

    // full stack holds off the acknowledge until a return pops it
    assign irqRequest = irqControl[cdsfi_pkg::IC_GIE] && !stackFull &&
                        (pick != cdsfi_pkg::CDSFI_SRC_NONE);
    assign wake = |(irqControl[6:4] & irqControl[3:1]);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqVector <= '0;
        end else if (irqRequest) begin
            case (pick)
                cdsfi_pkg::CDSFI_SRC_EXT: irqVector <= PC_W'(cdsfi_pkg::VEC_EXT);
                cdsfi_pkg::CDSFI_SRC_TMR: irqVector <= PC_W'(cdsfi_pkg::VEC_TMR);
                cdsfi_pkg::CDSFI_SRC_CNV: irqVector <= PC_W'(cdsfi_pkg::VEC_CNV);
                default: irqVector <= irqVector;
            endcase
        end
    end

    // pin edge detector; pin is taken as synchronous already
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extPinLast <= 1'b1;
        end else begin
            extPinLast <= extIrqPinN;
        end
    end

    // hardware set beats software clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqControl <= cdsfi_pkg::RESET_BYTE;
        end else begin
            logic [7:0] n;
            n = irqControl;
            if (wrEn && wrTarget == cdsfi_pkg::ADR_IRQCTL) begin
                n = newByte & cdsfi_pkg::IC_SW_MASK;
            end
            if (irqTake && irqRequest) begin
                n[cdsfi_pkg::IC_GIE] = 1'b0;
                case (pick)
                    cdsfi_pkg::CDSFI_SRC_EXT: n[cdsfi_pkg::IC_EXT_PEND] = 1'b0;
                    cdsfi_pkg::CDSFI_SRC_TMR: n[cdsfi_pkg::IC_TMR_PEND] = 1'b0;
                    cdsfi_pkg::CDSFI_SRC_CNV: n[cdsfi_pkg::IC_CNV_PEND] = 1'b0;
                    default: n = n;
                endcase
            end
            if (retFromIrq) begin
                n[cdsfi_pkg::IC_GIE] = 1'b1;
            end
            if (extPinLast && !extIrqPinN) begin
                n[cdsfi_pkg::IC_EXT_PEND] = 1'b1;
            end
            if (timerOverflow) begin
                n[cdsfi_pkg::IC_TMR_PEND] = 1'b1;
            end
            if (conversionDone) begin
                n[cdsfi_pkg::IC_CNV_PEND] = 1'b1;
            end
            irqControl <= n;
        end
    end
endmodule

// ===== cdsfi_core_properties.sv
// concurrent checks on the ports of the data space, flags and interrupt core
`timescale 1ns/1ps
module cdsfi_core_properties #(
    parameter int PC_W = 11
) (
    input wire logic clk,
    input wire logic rstn,
    input wire cdsfi_pkg::cdsfi_access_s acc,
    input wire logic [6:0] rdAddr,
    input wire logic [7:0] rdData,
    input wire cdsfi_pkg::cdsfi_alu_s alu,
    input wire logic [7:0] workIn,
    input wire logic workLoad,
    input wire logic retFromIrq,
    input wire logic stackFull,
    input wire logic irqTake,
    input wire logic [7:0] workingRegister,
    input wire logic [7:0] programCounterLow,
    input wire logic pclWritten,
    input wire logic irqRequest,
    input wire logic [PC_W-1:0] irqVector,
    input wire logic wake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic idle;
    assign idle = (acc.op == cdsfi_pkg::CDSFI_OP_NONE);
    a_full_blocks: assert property (stackFull |-> !irqRequest)
        else $error("request while stack full");
    a_req_wakes: assert property (irqRequest |-> wake)
        else $error("request without wake");
    a_take_drops: assert property (irqRequest && irqTake && !retFromIrq && idle |=> !irqRequest)
        else $error("request stays after acknowledge");
    a_ext_first: assert property (irqRequest && irqTake && rdAddr == 7'h0B && rdData[4] && rdData[1]
        |=> irqVector == 11'h004)
        else $error("external vector wrong");
    a_tmr_second: assert property (irqRequest && irqTake && rdAddr == 7'h0B
        && !(rdData[4] && rdData[1]) && rdData[5] && rdData[2] |=> irqVector == 11'h008)
        else $error("timer vector wrong");
    a_stat_top: assert property (rdAddr == 7'h0A |-> rdData[7:6] == 2'b00)
        else $error("status top bits not zero");
    a_gap_zero: assert property (rdAddr inside {7'h04, 7'h09, [7'h24:7'h27]} |-> rdData == 8'h00)
        else $error("unassigned location not zero");
    a_pcl_write: assert property (acc.op == cdsfi_pkg::CDSFI_OP_WRITE && acc.addr == 7'h06
        |=> pclWritten && programCounterLow == $past(acc.wdata))
        else $error("pc low write lost");
    a_work_load: assert property (workLoad && idle |=> workingRegister == $past(workIn))
        else $error("working register load lost");
    a_zero_flag: assert property (alu.valid && idle ##1 rdAddr == 7'h0A
        |-> rdData[2] == ($past(alu.result) == 8'h00))
        else $error("zero flag wrong");
    c_take: cover property (irqRequest && irqTake);
    c_full_wait: cover property (stackFull && wake);
    c_alu: cover property (alu.valid);
endmodule
bind cdsfi_core cdsfi_core_properties #(.PC_W(PC_W)) u_props (.clk(clk), .rstn(rstn), .acc(acc),
    .rdAddr(rdAddr), .rdData(rdData), .alu(alu), .workIn(workIn), .workLoad(workLoad),
    .retFromIrq(retFromIrq), .stackFull(stackFull), .irqTake(irqTake),
    .workingRegister(workingRegister), .programCounterLow(programCounterLow),
    .pclWritten(pclWritten), .irqRequest(irqRequest), .irqVector(irqVector), .wake(wake));

// ===== cdsfi_pipe_model.sv
// return stack and acknowledge model standing behind the core
`timescale 1ns/1ps
module cdsfi_pipe_model #(
    parameter int DEPTH = 6
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic irqRequest,
    input wire logic takeEn,
    input wire logic callPush,
    input wire logic retPop,
    output logic stackFull,
    output logic irqTake
);
    int level;
    // a slow pipeline holds takeEn low and leaves the request waiting
    assign irqTake = irqRequest && takeEn;
    assign stackFull = (level >= DEPTH);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level <= 0;
        end else if ((irqTake || callPush) && level < DEPTH) begin
            level <= level + 1;
        end else if (retPop && level > 0) begin
            level <= level - 1;
        end
    end
endmodule

// ===== cdsfi_core_tb_top.sv
// testbench for the data space, flags and interrupt core
`timescale 1ns/1ps
module cdsfi_core_tb_top;
    localparam cdsfi_pkg::cdsfi_op_e WR = cdsfi_pkg::CDSFI_OP_WRITE;
    localparam cdsfi_pkg::cdsfi_op_e BS = cdsfi_pkg::CDSFI_OP_BITSET;
    localparam cdsfi_pkg::cdsfi_op_e BC = cdsfi_pkg::CDSFI_OP_BITCLR;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    cdsfi_pkg::cdsfi_access_s acc = '0;
    cdsfi_pkg::cdsfi_alu_s alu = '0;
    logic [6:0] rdAddr = 7'h00;
    // 0 sleep, 1 wdt clear, 2 timeout, 3 return, 4 timer, 5 conv, 6 work, 7 table, 8 call
    logic [9:0] ev = 10'h000;
    logic extPinN = 1'b1;
    logic takeEn = 1'b0;
    logic [7:0] rdData, workReg, program_counter_low, tblPtr;
    logic [10:0] vec;
    logic pclWr, irqReq, wake, stackFull, irqTake;
    int numErrors = 0;
    int nCompared = 0;
    cdsfi_core u_dut (.clk(clk), .rstn(rstn), .acc(acc), .rdAddr(rdAddr), .rdData(rdData),
        .alu(alu), .workIn(8'h3C), .workLoad(ev[6]), .pcLowIn(8'h77), .tableHighIn(8'h5A),
        .tableHighLoad(ev[7]), .sleepExec(ev[0]), .wdtClearExec(ev[1]), .wdtTimeout(ev[2]),
        .retFromIrq(ev[3]), .stackFull(stackFull), .irqTake(irqTake), .extIrqPinN(extPinN),
        .timerOverflow(ev[4]), .conversionDone(ev[5]), .workingRegister(workReg),
        .programCounterLow(program_counter_low), .tablePointer(tblPtr), .pclWritten(pclWr),
        .irqRequest(irqReq), .irqVector(vec), .wake(wake));
    cdsfi_pipe_model u_pipe (.clk(clk), .rstn(rstn), .irqRequest(irqReq), .takeEn(takeEn),
        .callPush(ev[8]), .retPop(ev[3]), .stackFull(stackFull), .irqTake(irqTake));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic finalReport;
        $display("compared %0d, mismatched %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input cdsfi_pkg::cdsfi_op_e op, input logic [6:0] a, input logic [7:0] d,
            input logic [2:0] b);
        @(posedge clk) acc <= '{op, a, d, b};
        @(posedge clk) acc <= '0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk) rdAddr <= a;
        @(negedge clk) chk(rdData, exp);
    endtask
    task automatic pulse(input logic [9:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 10'h000;
    endtask
    task automatic aluop(input logic [4:0] f, input logic [7:0] r);
        @(posedge clk) alu <= {1'b1, f, r};
        @(posedge clk) alu <= '0;
    endtask
    // the pipeline stalls until asked, so requests are seen waiting first
    task automatic take(input logic [10:0] v);
        int i;
        @(posedge clk) takeEn <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (irqTake === 1'b1) break;
        end
        if (i == 40) begin
            numErrors++;
            finalReport();
        end
        @(posedge clk) takeEn <= 1'b0;
        @(negedge clk) chk(vec, v);
    endtask
    task automatic done(input string s);
        $display("test %0s finished", s);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(7'h0A, 8'h00);
        wr(WR, 7'h0B, 8'h80, 3'h0);
        rd(7'h0B, 8'h00);
        wr(WR, 7'h28, 8'h11, 3'h0);
        wr(WR, 7'h7F, 8'h22, 3'h0);
        rd(7'h28, 8'h11);
        rd(7'h7F, 8'h22);
        wr(WR, 7'h04, 8'h55, 3'h0);
        rd(7'h04, 8'h00);
        rd(7'h24, 8'h00);
        wr(WR, 7'h01, 8'h30, 3'h0);
        wr(WR, 7'h00, 8'hA5, 3'h0);
        rd(7'h30, 8'hA5);
        rd(7'h00, 8'hA5);
        wr(WR, 7'h03, 8'h02, 3'h0);
        wr(WR, 7'h02, 8'h99, 3'h0);
        rd(7'h02, 8'h00);
        wr(WR, 7'h03, 8'h28, 3'h0);
        rd(7'h02, 8'h11);
        wr(BS, 7'h7F, 8'h00, 3'h7);
        wr(BC, 7'h7F, 8'h00, 3'h1);
        rd(7'h7F, 8'hA0);
        pulse(10'h0C0);
        @(negedge clk);
        chk(workReg, 8'h3C);
        wr(WR, 7'h05, 8'hC3, 3'h0);
        rd(7'h05, 8'hC3);
        wr(WR, 7'h07, 8'h9A, 3'h0);
        @(negedge clk);
        chk(tblPtr, 8'h9A);
        wr(WR, 7'h08, 8'h00, 3'h0);
        rd(7'h08, 8'h5A);
        wr(WR, 7'h06, 8'h44, 3'h0);
        @(negedge clk);
        chk({pclWr, program_counter_low}, 9'h144);
        rd(7'h06, 8'h77);
        done("map");
        wr(WR, 7'h0A, 8'hFF, 3'h0);
        rd(7'h0A, 8'h0F);
        wr(BS, 7'h0A, 8'h00, 3'h5);
        rd(7'h0A, 8'h0F);
        pulse(10'h001);
        rd(7'h0A, 8'h1F);
        pulse(10'h004);
        rd(7'h0A, 8'h3F);
        pulse(10'h001);
        rd(7'h0A, 8'h1F);
        pulse(10'h002);
        rd(7'h0A, 8'h0F);
        wr(WR, 7'h0A, 8'h00, 3'h0);
        aluop(5'h1F, 8'h00);
        rd(7'h0A, 8'h07);
        aluop(5'h15, 8'h80);
        rd(7'h0A, 8'h08);
        aluop(5'h00, 8'h00);
        rd(7'h0A, 8'h0C);
        done("status");
        wr(WR, 7'h0B, 8'h0F, 3'h0);
        @(posedge clk) extPinN <= 1'b0;
        pulse(10'h030);
        rd(7'h0B, 8'h7F);
        chk(wake, 1'b1);
        take(cdsfi_pkg::VEC_EXT);
        @(posedge clk) extPinN <= 1'b1;
        rd(7'h0B, 8'h6E);
        wr(BS, 7'h0B, 8'h00, 3'h0);
        take(cdsfi_pkg::VEC_TMR);
        rd(7'h0B, 8'h4E);
        pulse(10'h008);
        take(cdsfi_pkg::VEC_CNV);
        rd(7'h0B, 8'h0E);
        rd(7'h0A, 8'h0C);
        done("irq");
        repeat (4) pulse(10'h100);
        @(posedge clk) extPinN <= 1'b0;
        wr(BS, 7'h0B, 8'h00, 3'h0);
        repeat (8) begin
            @(negedge clk);
            chk({wake, irqReq}, 2'b10);
        end
        pulse(10'h008);
        take(cdsfi_pkg::VEC_EXT);
        done("stack");
        finalReport();
    end
endmodule
